// file: core/nfs_defines.vh
// command words, fixed addresses, status bit positions and bus timing for the nor flash host
// assumes a 16-bit word-mode flash bus with 23 address lines
`ifndef NFS_DEFINES_VH
`define NFS_DEFINES_VH

// user operation codes
`define NFS_OP_RESET 3'h0
`define NFS_OP_PROG 3'h1
`define NFS_OP_CHIP 3'h2
`define NFS_OP_BLOCK 3'h3
`define NFS_OP_ASEL 3'h4
`define NFS_OP_WBUF 3'h5
`define NFS_OP_EBUF 3'h6

// result codes
`define NFS_RES_OK 2'h0
`define NFS_RES_FAIL 2'h1
`define NFS_RES_ABORT 2'h2
`define NFS_RES_REFUSED 2'h3

// unlock addresses and command data
`define NFS_A_UNLK1 23'h000555
`define NFS_A_UNLK2 23'h0002AA
`define NFS_D_UNLK1 16'h00AA
`define NFS_D_UNLK2 16'h0055
`define NFS_D_PROG 16'h00A0
`define NFS_D_ERASE 16'h0080
`define NFS_D_CHIP 16'h0010
`define NFS_D_BLOCK 16'h0030
`define NFS_D_ASEL 16'h0090
`define NFS_D_RESET 16'h00F0
`define NFS_D_WBUF_SETUP 16'h0025
`define NFS_D_WBUF_CONF 16'h0029
`define NFS_D_EBUF_SETUP 16'h0033
`define NFS_D_EBUF_CONF 16'h0029

// status bit positions on the data bus
`define NFS_ABORT_FLAG_BIT 1
`define NFS_ERROR_FLAG_BIT 5
`define NFS_TOGGLE_FLAG_BIT 6
`define NFS_POLLING_FLAG_BIT 7

// buffer sizes in words
`define NFS_WBUF_WORDS 32
`define NFS_EBUF_WORDS 256

// bus timing
`define NFS_CLK_NS 8
`define NFS_T_WP_NS 35
`define NFS_T_ACC_NS 70
`define NFS_T_REC_NS 30

`endif

// file: core/nfs_host.v
// host controller driving a parallel nor flash through its command sequences
// assumes the flash pins are sampled synchronously to mclk and the user holds cmd fields stable
`include "nfs_defines.vh"

module nfs_host #(
  parameter WBUF_WORDS = `NFS_WBUF_WORDS,
  parameter EBUF_WORDS = `NFS_EBUF_WORDS
) (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // user command port
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [22:0] cmd_addr,
  input wire [15:0] cmd_data,
  input wire [7:0] cmd_count,
  output reg busy_r,
  output reg done_r,
  output reg [1:0] result_r,
  output reg [15:0] rd_data_r,
  // buffer load stream
  input wire ld_valid,
  input wire [15:0] ld_data,
  output reg ld_ready_r,
  // supply level detect
  input wire high_program_voltage_level,
  // flash pins
  output reg [22:0] flash_addr_r,
  output reg [15:0] dq_out_r,
  output reg dq_oe_r,
  input wire [15:0] dq_in,
  output reg ce_n_r,
  output reg we_n_r,
  output reg oe_n_r
);

  localparam [7:0] T_WP = (`NFS_T_WP_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS;
  localparam [7:0] T_ACC = (`NFS_T_ACC_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS;
  localparam [7:0] T_REC = (`NFS_T_REC_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS;
  localparam [8:0] EBUF_LAST = EBUF_WORDS - 1;

  localparam [2:0] B_IDLE = 3'h1;
  localparam [2:0] B_ACT = 3'h2;
  localparam [2:0] B_REC = 3'h4;

  localparam [7:0] M_IDLE = 8'h01;
  localparam [7:0] M_PRE = 8'h02;
  localparam [7:0] M_LOAD = 8'h04;
  localparam [7:0] M_CONF = 8'h08;
  localparam [7:0] M_ARD = 8'h10;
  localparam [7:0] M_POLL = 8'h20;
  localparam [7:0] M_VFY = 8'h40;
  localparam [7:0] M_EXIT = 8'h80;

  // one command write of a standard sequence: {address, data}
  function [38:0] seq_word;
    input [2:0] op;
    input [2:0] st;
    input [22:0] a;
    input [15:0] d;
    input [7:0] n;
    begin
      seq_word = {`NFS_A_UNLK2, `NFS_D_UNLK2};
      case (st)
        3'h0: seq_word = (op == `NFS_OP_RESET) ? {23'h000000, `NFS_D_RESET} :
                         {`NFS_A_UNLK1, `NFS_D_UNLK1};
        3'h2: begin
          case (op)
            `NFS_OP_PROG: seq_word = {`NFS_A_UNLK1, `NFS_D_PROG};
            `NFS_OP_ASEL: seq_word = {({a[22:11], 11'h000} | `NFS_A_UNLK1), `NFS_D_ASEL};
            `NFS_OP_WBUF: seq_word = {a, `NFS_D_WBUF_SETUP};
            `NFS_OP_EBUF: seq_word = {a, `NFS_D_EBUF_SETUP};
            default: seq_word = {`NFS_A_UNLK1, `NFS_D_ERASE};
          endcase
        end
        3'h3: begin
          case (op)
            `NFS_OP_PROG: seq_word = {a, d};
            `NFS_OP_WBUF: seq_word = {a, 8'h00, n};
            default: seq_word = {`NFS_A_UNLK1, `NFS_D_UNLK1};
          endcase
        end
        3'h5: seq_word = (op == `NFS_OP_CHIP) ? {`NFS_A_UNLK1, `NFS_D_CHIP} : {a, `NFS_D_BLOCK};
        default: seq_word = {`NFS_A_UNLK2, `NFS_D_UNLK2};
      endcase
    end
  endfunction

  function [2:0] last_step;
    input [2:0] op;
    begin
      case (op)
        `NFS_OP_RESET: last_step = 3'h0;
        `NFS_OP_ASEL: last_step = 3'h2;
        `NFS_OP_EBUF: last_step = 3'h2;
        `NFS_OP_CHIP: last_step = 3'h5;
        `NFS_OP_BLOCK: last_step = 3'h5;
        default: last_step = 3'h3;
      endcase
    end
  endfunction

  reg rst_s1_r;
  reg rst_n_r;
  reg [2:0] bst_r;
  reg [7:0] bcnt_r;
  reg bus_go_r;
  reg bus_rd_r;
  reg [22:0] bus_addr_r;
  reg [15:0] bus_dat_r;
  reg bus_done_r;
  reg [15:0] bus_q_r;
  reg [7:0] mst_r;
  reg pend_r;
  reg [2:0] op_r;
  reg [22:0] addr_r;
  reg [15:0] dat_r;
  reg [7:0] n_r;
  reg [2:0] step_r;
  reg [8:0] ldc_r;
  reg [15:0] last_r;
  reg first_r;
  reg tog_r;
  reg exit_abort_r;
  reg [1:0] exit_res_r;
  reg bypass_r;

  wire [38:0] pre_word = seq_word(op_r, step_r, addr_r, dat_r, n_r);
  wire [4:0] wb_low = addr_r[4:0] + ldc_r[4:0];
  wire [8:0] wb_end = {4'h0, cmd_addr[4:0]} + {1'b0, cmd_count};
  wire [8:0] ld_total = (op_r == `NFS_OP_WBUF) ? {1'b0, n_r} : EBUF_LAST;
  wire bufop = (op_r == `NFS_OP_WBUF) || (op_r == `NFS_OP_EBUF);
  wire progop = (cmd_op == `NFS_OP_PROG) || (cmd_op == `NFS_OP_WBUF) ||
                (cmd_op == `NFS_OP_EBUF);
  wire [22:0] ld_addr;
  wire take = (mst_r == M_LOAD) && ld_valid && ld_ready_r;
  wire step_ok = pend_r && bus_done_r;

  // each load address is used once, so no load overwrites another
  // small-buffer loads keep A22-A5; enhanced keeps A22-A8
  assign ld_addr = (op_r == `NFS_OP_WBUF) ? {addr_r[22:5], wb_low} : {addr_r[22:8], ldc_r[7:0]};

  // reset release through two flops
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // one asynchronous bus cycle per request, chip enable and strobe together
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bst_r <= B_IDLE;
      bcnt_r <= 8'h00;
      bus_done_r <= 1'b0;
      bus_q_r <= 16'h0000;
      flash_addr_r <= 23'h000000;
      dq_out_r <= 16'h0000;
      dq_oe_r <= 1'b0;
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else begin
      bus_done_r <= 1'b0;
      case (bst_r)
        B_IDLE: begin
          if (bus_go_r) begin
            flash_addr_r <= bus_addr_r;
            dq_out_r <= bus_dat_r;
            dq_oe_r <= ~bus_rd_r;
            ce_n_r <= 1'b0;
            we_n_r <= bus_rd_r;
            oe_n_r <= ~bus_rd_r;
            bcnt_r <= bus_rd_r ? T_ACC : T_WP;
            bst_r <= B_ACT;
          end
        end
        B_ACT: begin
          if (bcnt_r == 8'h01) begin
            if (!oe_n_r)
              bus_q_r <= dq_in;
            ce_n_r <= 1'b1;
            we_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            bcnt_r <= T_REC;
            bst_r <= B_REC;
          end else begin
            bcnt_r <= bcnt_r - 8'h01;
          end
        end
        B_REC: begin
          // data held past the rising strobe for the recovery time
          if (bcnt_r == 8'h01) begin
            dq_oe_r <= 1'b0;
            bus_done_r <= 1'b1;
            bst_r <= B_IDLE;
          end else begin
            bcnt_r <= bcnt_r - 8'h01;
          end
        end
        default: bst_r <= B_IDLE;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mst_r <= M_IDLE;
      pend_r <= 1'b0;
      bus_go_r <= 1'b0;
      bus_rd_r <= 1'b0;
      bus_addr_r <= 23'h000000;
      bus_dat_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= `NFS_RES_OK;
      rd_data_r <= 16'h0000;
      ld_ready_r <= 1'b0;
      op_r <= `NFS_OP_RESET;
      addr_r <= 23'h000000;
      dat_r <= 16'h0000;
      n_r <= 8'h00;
      step_r <= 3'h0;
      ldc_r <= 9'h000;
      last_r <= 16'h0000;
      first_r <= 1'b1;
      tog_r <= 1'b0;
      exit_abort_r <= 1'b0;
      exit_res_r <= `NFS_RES_OK;
      bypass_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      bus_go_r <= 1'b0;
      // high program voltage puts the device in bypass
      bypass_r <= high_program_voltage_level;
      if (bus_go_r)
        pend_r <= 1'b1;
      else if (bus_done_r)
        pend_r <= 1'b0;
      case (mst_r)
        M_IDLE: begin
          if (cmd_valid) begin
            op_r <= cmd_op;
            dat_r <= cmd_data;
            n_r <= cmd_count;
            ldc_r <= 9'h000;
            first_r <= 1'b1;
            // enhanced loads start at low byte zero
            addr_r <= (cmd_op == `NFS_OP_EBUF) ? {cmd_addr[22:8], 8'h00} : cmd_addr;
            // program-type commands skip unlocks in bypass
            step_r <= (bypass_r && progop) ? 3'h2 : 3'h0;
            // refuse counts that leave the buffer page
            if ((cmd_op == `NFS_OP_WBUF) && (wb_end > WBUF_WORDS - 1)) begin
              result_r <= `NFS_RES_REFUSED;
              done_r <= 1'b1;
            end else if (cmd_op > `NFS_OP_EBUF) begin
              result_r <= `NFS_RES_REFUSED;
              done_r <= 1'b1;
            end else begin
              busy_r <= 1'b1;
              mst_r <= M_PRE;
            end
          end
        end
        M_PRE: begin
          if (!pend_r && !bus_go_r) begin
            {bus_addr_r, bus_dat_r} <= pre_word;
            bus_rd_r <= 1'b0;
            bus_go_r <= 1'b1;
          end else if (step_ok) begin
            step_r <= step_r + 3'h1;
            if (step_r == last_step(op_r)) begin
              if (op_r == `NFS_OP_RESET) begin
                result_r <= `NFS_RES_OK;
                done_r <= 1'b1;
                busy_r <= 1'b0;
                mst_r <= M_IDLE;
              end else if (op_r == `NFS_OP_ASEL) begin
                mst_r <= M_ARD;
              end else if (bufop) begin
                ld_ready_r <= 1'b1;
                mst_r <= M_LOAD;
              end else begin
                mst_r <= M_POLL;
              end
            end
          end
        end
        M_LOAD: begin
          // loads issued at consecutive addresses in order
          if (take) begin
            ld_ready_r <= 1'b0;
            bus_addr_r <= ld_addr;
            bus_dat_r <= ld_data;
            last_r <= ld_data;
            bus_rd_r <= 1'b0;
            bus_go_r <= 1'b1;
          end else if (step_ok) begin
            ldc_r <= ldc_r + 9'h001;
            if (ldc_r == ld_total)
              mst_r <= M_CONF;
            else
              ld_ready_r <= 1'b1;
          end
        end
        M_CONF: begin
          // confirm, then the device runs its own cycle before polling
          if (!pend_r && !bus_go_r) begin
            bus_addr_r <= addr_r;
            bus_dat_r <= bufop && (op_r == `NFS_OP_WBUF) ? `NFS_D_WBUF_CONF : `NFS_D_EBUF_CONF;
            bus_rd_r <= 1'b0;
            bus_go_r <= 1'b1;
          end else if (step_ok) begin
            mst_r <= M_POLL;
          end
        end
        M_POLL: begin
          // status read inside the bank being programmed
          if (!pend_r && !bus_go_r) begin
            bus_addr_r <= addr_r;
            bus_rd_r <= 1'b1;
            bus_go_r <= 1'b1;
          end else if (step_ok) begin
            first_r <= 1'b0;
            tog_r <= bus_q_r[`NFS_TOGGLE_FLAG_BIT];
            step_r <= 3'h0;
            if (!first_r && (tog_r == bus_q_r[`NFS_TOGGLE_FLAG_BIT])) begin
              if (op_r == `NFS_OP_PROG) begin
                mst_r <= M_VFY;
              end else begin
                result_r <= `NFS_RES_OK;
                done_r <= 1'b1;
                busy_r <= 1'b0;
                mst_r <= M_IDLE;
              end
            // abort: bit set, polling bit inverted; full abort-reset follows
            end else if (bufop && bus_q_r[`NFS_ABORT_FLAG_BIT] &&
                         (bus_q_r[`NFS_POLLING_FLAG_BIT] != last_r[`NFS_POLLING_FLAG_BIT])) begin
              exit_abort_r <= 1'b1;
              exit_res_r <= `NFS_RES_ABORT;
              mst_r <= M_EXIT;
            // error keeps status up until a reset command
            end else if (bus_q_r[`NFS_ERROR_FLAG_BIT]) begin
              exit_abort_r <= 1'b0;
              exit_res_r <= `NFS_RES_FAIL;
              mst_r <= M_EXIT;
            end
          end
        end
        M_VFY: begin
          if (!pend_r && !bus_go_r) begin
            bus_addr_r <= addr_r;
            bus_rd_r <= 1'b1;
            bus_go_r <= 1'b1;
          end else if (step_ok) begin
            // a one cannot be cleared back, so readback differs
            rd_data_r <= bus_q_r;
            result_r <= (bus_q_r == dat_r) ? `NFS_RES_OK : `NFS_RES_FAIL;
            done_r <= 1'b1;
            busy_r <= 1'b0;
            mst_r <= M_IDLE;
          end
        end
        M_ARD: begin
          // identification read from the selected bank
          if (!pend_r && !bus_go_r) begin
            bus_addr_r <= addr_r;
            bus_rd_r <= 1'b1;
            bus_go_r <= 1'b1;
          end else if (step_ok) begin
            rd_data_r <= bus_q_r;
            exit_abort_r <= 1'b0;
            exit_res_r <= `NFS_RES_OK;
            step_r <= 3'h0;
            mst_r <= M_EXIT;
          end
        end
        M_EXIT: begin
          // F0 puts the device back in read mode
          if (!pend_r && !bus_go_r) begin
            bus_rd_r <= 1'b0;
            bus_go_r <= 1'b1;
            if (!exit_abort_r || step_r == 3'h2)
              {bus_addr_r, bus_dat_r} <= {`NFS_A_UNLK1, `NFS_D_RESET};
            else if (step_r == 3'h0)
              {bus_addr_r, bus_dat_r} <= {`NFS_A_UNLK1, `NFS_D_UNLK1};
            else
              {bus_addr_r, bus_dat_r} <= {`NFS_A_UNLK2, `NFS_D_UNLK2};
          end else if (step_ok) begin
            step_r <= step_r + 3'h1;
            if (!exit_abort_r || step_r == 3'h2) begin
              result_r <= exit_res_r;
              done_r <= 1'b1;
              busy_r <= 1'b0;
              mst_r <= M_IDLE;
            end
          end
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end

endmodule // nfs_host

// file: test/nfs_host_assertions.sv
// port checks for the nor flash host
// assumes a single mclk domain with arst_n as its reset
module nfs_host_assertions (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // user side
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [22:0] cmd_addr,
  input wire [7:0] cmd_count,
  input wire busy_r,
  input wire done_r,
  input wire [1:0] result_r,
  input wire ld_valid,
  input wire ld_ready_r,
  // flash pins
  input wire [22:0] flash_addr_r,
  input wire [15:0] dq_out_r,
  input wire dq_oe_r,
  input wire ce_n_r,
  input wire we_n_r,
  input wire oe_n_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire take = cmd_valid && !busy_r && !done_r;
  wire big = {4'h0, cmd_addr[4:0]} + {1'b0, cmd_count} > 9'h01F;
  wire bad = cmd_op == 3'h7 || (cmd_op == 3'h5 && big);
  sequence strobe_s;
    (!we_n_r && !ce_n_r)[*5] ##1 (we_n_r && ce_n_r);
  endsequence
  sequence hold_s;
    (dq_oe_r && $stable(dq_out_r) && $stable(flash_addr_r))[*4] ##1 !dq_oe_r;
  endsequence
  write_cycle_a: assert property ($fell(we_n_r) |-> strobe_s ##0 hold_s)
    else $error("write strobe or hold time wrong");
  read_window_a: assert property ($fell(oe_n_r) |->
    (!oe_n_r && !ce_n_r && !dq_oe_r)[*8] ##1 !oe_n_r ##1 oe_n_r)
    else $error("read window wrong");
  bus_excl_a: assert property (!(!we_n_r && !oe_n_r))
    else $error("read and write strobes together");
  unlock_one_a: assert property ($fell(we_n_r) && dq_out_r == 16'h00AA |->
    flash_addr_r[10:0] == 11'h555)
    else $error("first unlock at wrong address");
  unlock_two_a: assert property ($fell(we_n_r) && dq_out_r == 16'h0055 |->
    flash_addr_r[10:0] == 11'h2AA)
    else $error("second unlock at wrong address");
  no_ff_a: assert property ($fell(we_n_r) && flash_addr_r[10:0] == 11'h555 |->
    dq_out_r != 16'h00FF)
    else $error("all-ones command written");
  refuse_code_a: assert property (take && bad |-> ##[1:2] (done_r && result_r == 2'h3))
    else $error("refusal not reported");
  refuse_quiet_a: assert property (take && bad |-> we_n_r[*4])
    else $error("bus activity on refused command");
  start_busy_a: assert property (take && !bad |=> busy_r)
    else $error("busy not raised");
  done_pulse_a: assert property ($rose(done_r) |=> !done_r)
    else $error("done longer than one cycle");
  load_take_a: assert property (ld_valid && ld_ready_r |=> !ld_ready_r)
    else $error("ready kept after a load");
endmodule // nfs_host_assertions

bind nfs_host nfs_host_assertions u_nfs_host_assertions (.mclk, .arst_n, .cmd_valid,
  .cmd_op, .cmd_addr, .cmd_count, .busy_r, .done_r, .result_r, .ld_valid, .ld_ready_r,
  .flash_addr_r, .dq_out_r, .dq_oe_r, .ce_n_r, .we_n_r, .oe_n_r);

// file: test/nfs_flash_model.sv
// behavioural flash: command decoder, array, status and buffered program
// assumes word mode; a write latches when the write strobe rises
module nfs_flash_model #(
  parameter [15:0] ID_CODE = 16'h5A5A, // arbitrary identification value
  parameter BANK_SH = 21
) (
  // flash pins
  input wire [22:0] flash_addr_r,
  input wire [15:0] dq_out_r,
  input wire ce_n_r,
  input wire we_n_r,
  input wire oe_n_r,
  output wire [15:0] dq_in,
  // bypass and fault controls
  input wire hv,
  input wire err_inj,
  input wire abt_inj
);
  logic [15:0] mem [logic [22:0]];
  logic [15:0] bd [logic [22:0]];
  logic [15:0] last = 16'h0000;
  logic [15:0] q = 16'h0000;
  logic [22:0] pg = 23'h000000;
  logic [7:0] cmd = 8'h00;
  logic tog = 1'b0, err = 1'b0, abt = 1'b0, asel = 1'b0;
  int st = 0, busy = 0, n = 0, ld = 0, nwr = 0;
  wire [22:0] a = flash_addr_r;
  wire [15:0] d = dq_out_r;
  wire stat = (busy > 0 || err || abt) && a[22:BANK_SH] == pg[22:BANK_SH];
  function automatic logic [15:0] rd(input logic [22:0] x);
    return mem.exists(x) ? mem[x] : 16'h0000;
  endfunction
  task automatic go;
    busy = 3;
    pg = a;
    err = err_inj;
    st = 0;
  endtask
  // last load wins, address off the page aborts
  task automatic load(input logic bad);
    last = d;
    bd[a] = d;
    if (bad) begin
      abt = 1'b1;
      st = 0;
    end
  endtask
  task automatic confirm;
    if (d != 16'h0029 || abt_inj) begin
      abt = 1'b1;
      st = 0;
    end else begin
      foreach (bd[k]) mem[k] = rd(k) | bd[k];
      go();
    end
  endtask
  // no pull-up: a released bus shows the inverse of the last value
  assign dq_in = (!ce_n_r && !oe_n_r) ? q : ~q;
  // status only in the busy bank
  always @(negedge oe_n_r) #1 q = stat ? {8'h00, ~last[7], tog, err, 3'h0, abt, 1'b0} :
    (asel && a[22:BANK_SH] == pg[22:BANK_SH]) ? ID_CODE : rd(a);
  always @(posedge oe_n_r) begin
    if (busy > 0 || err || abt) tog = ~tog;
    if (busy > 0) busy--;
  end
  always @(posedge we_n_r) begin
    nwr++;
    if (st < 3 && d == 16'h00F0) begin
      st = 0;
      err = 1'b0;
      abt = 1'b0;
      asel = 1'b0;
    end else if (st == 2 || (st == 0 && hv && d != 16'h00AA)) begin
      cmd = d[7:0];
      pg = a;
      ld = 0;
      bd.delete();
      asel = d == 16'h0090;
      st = asel ? 0 : 3;
    end else if (st < 2) begin
      st = (d == (st == 0 ? 16'h00AA : 16'h0055)) ? st + 1 : 0;
    end else begin
      ld++;
      case (cmd)
        8'hA0: begin
          mem[a] = rd(a) | d;
          last = d;
          go();
        end
        8'h80: if (ld == 3) begin
          if (d == 16'h0010) mem.delete();
          go();
        end
        8'h25: if (ld == 1) begin
          n = d[7:0] + 1;
          if (n > 32) load(1'b1);
        end else if (ld <= n + 1) load(a[22:5] != pg[22:5]);
        else confirm();
        8'h33: if (ld <= 256) load(a[22:8] != pg[22:8] || a[7:0] != ld - 1);
        else confirm();
        default: st = 0;
      endcase
    end
  end
endmodule // nfs_flash_model

// file: test/nfs_host_bench.sv
// bench for the nor flash host against the behavioural flash
// assumes the checker is bound to nfs_host by its own file
module nfs_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [22:0] cmd_addr = 23'h000000;
  logic [15:0] cmd_data = 16'h0000;
  logic [7:0] cmd_count = 8'h00;
  logic ld_valid = 1'b0;
  logic [15:0] ld_data = 16'h0084;
  logic hv = 1'b0;
  logic err_inj = 1'b0;
  logic abt_inj = 1'b0;
  wire busy_r, done_r, ld_ready_r, dq_oe_r, ce_n_r, we_n_r, oe_n_r;
  wire [1:0] result_r;
  wire [15:0] rd_data_r, dq_out_r, dq_in;
  wire [22:0] flash_addr_r;
  int error_cnt = 0;
  int n_tests = 0;
  int nld = 0;
  int w0 = 0;
  always #4 mclk = ~mclk;
  nfs_host u_nfs_host (.mclk, .arst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data,
    .cmd_count, .busy_r, .done_r, .result_r, .rd_data_r, .ld_valid, .ld_data,
    .ld_ready_r, .high_program_voltage_level(hv), .flash_addr_r, .dq_out_r, .dq_oe_r,
    .dq_in, .ce_n_r, .we_n_r, .oe_n_r);
  nfs_flash_model u_nfs_flash_model (.flash_addr_r, .dq_out_r, .ce_n_r, .we_n_r,
    .oe_n_r, .dq_in, .hv, .err_inj, .abt_inj);
  // load word i is {i, 84h} so it never looks like a status or command value
  always @(posedge mclk) begin
    if (cmd_valid) begin
      nld <= 0;
      ld_data <= 16'h0084;
    end else if (ld_valid && ld_ready_r) begin
      nld <= nld + 1;
      ld_data <= {nld[7:0] + 8'h01, 8'h84};
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one command; res is its result, nw the number of flash writes it makes
  task automatic run(input logic [2:0] op, input logic [22:0] a, input logic [15:0] d,
      input logic [7:0] n, input logic [1:0] res, input int nw);
    int k;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_count <= n;
    ld_valid <= op == 3'h5 || op == 3'h6;
    w0 = u_nfs_flash_model.nwr;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    k = 0;
    while (done_r !== 1'b1 && k < 20000) begin
      @(negedge mclk);
      k++;
    end
    check(result_r, res);
    check(u_nfs_flash_model.nwr - w0, nw);
    @(posedge mclk);
    ld_valid <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    run(3'h7, 23'h000000, 16'h0000, 8'h00, 2'h3, 0); // unknown op refused
    run(3'h0, 23'h000000, 16'h0000, 8'h00, 2'h0, 1); // lone reset write
    run(3'h1, 23'h000100, 16'h12C4, 8'h00, 2'h0, 4); // four-write program
    check(rd_data_r, 16'h12C4); // readback
    run(3'h1, 23'h000100, 16'h0008, 8'h00, 2'h1, 4); // reprogram fails
    check(u_nfs_flash_model.rd(23'h000100), 16'h12CC); // cells ored
    err_inj <= 1'b1;
    run(3'h1, 23'h000200, 16'h00C4, 8'h00, 2'h1, 5); // error then reset
    err_inj <= 1'b0;
    run(3'h1, 23'h000201, 16'h00C4, 8'h00, 2'h0, 4); // read mode again
    hv <= 1'b1;
    run(3'h1, 23'h000300, 16'h00C4, 8'h00, 2'h0, 2); // no unlocks
    run(3'h5, 23'h000600, 16'h0000, 8'h00, 2'h0, 4); // short buffer program
    hv <= 1'b0;
    run(3'h2, 23'h000000, 16'h0000, 8'h00, 2'h0, 6); // six writes
    check(u_nfs_flash_model.rd(23'h000100), 16'h0000); // array cleared
    run(3'h3, 23'h400000, 16'h0000, 8'h00, 2'h0, 6); // six writes
    run(3'h4, 23'h012345, 16'h0000, 8'h00, 2'h0, 4); // entry, read, exit
    check(rd_data_r, 16'h5A5A); // identification word
    run(3'h5, 23'h000405, 16'h0000, 8'h1A, 2'h0, 32); // page end
    check(u_nfs_flash_model.rd(23'h00041F), 16'h1A84); // last word
    check(u_nfs_flash_model.rd(23'h000405), 16'h0084); // first word
    run(3'h5, 23'h000405, 16'h0000, 8'h1B, 2'h3, 0); // one word too many
    run(3'h6, 23'h012300, 16'h0000, 8'h00, 2'h0, 260); // full page
    check(u_nfs_flash_model.rd(23'h0123FF), 16'hFF84); // top word
    abt_inj <= 1'b1;
    run(3'h5, 23'h000700, 16'h0000, 8'h01, 2'h2, 10); // abort seen
    abt_inj <= 1'b0;
    run(3'h5, 23'h000720, 16'h0000, 8'h00, 2'h0, 6); // next op accepted
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end
endmodule // nfs_host_bench
